// ===== test/eii_cpu_model.sv
// cpu core model: accepts presented requests after a chosen lag and mirrors the mask level
`timescale 1ns/1ps

module eii_cpu_model
  import eii_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       take,
  input  wire logic [3:0] lag,
  input  wire eii_req_t   cpu_req,
  input  wire eii_mask_t  cpu_mask,
  output eii_ack_t        cpu_ack,
  output logic      [2:0] cpu_mask_level
);
  logic [3:0] wait_cnt;
  logic [3:0] busy;

  // ------------------------------------------------------------
  // accept and handler span
  // ------------------------------------------------------------
  // the busy span stands for the handler: no new accept until it returns the mask to 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_ack        <= '0;
      cpu_mask_level <= 3'h0;
      wait_cnt       <= 4'h0;
      busy           <= 4'h0;
    end else begin
      cpu_ack <= '0;
      if (cpu_mask.update) cpu_mask_level <= cpu_mask.level;
      if (busy != 4'h0) begin
        busy <= busy - 4'h1;
        if (busy == 4'h1) cpu_mask_level <= 3'h0;
      end else if (take && cpu_req.valid) begin
        if (wait_cnt == lag) begin
          cpu_ack  <= '{accept: 1'b1, source: cpu_req.source};
          busy     <= 4'hC;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule

// ===== test/testbench.sv
// testbench: register map, pin sensing and accept sequence of the external interrupt inputs
`timescale 1ns/1ps

module testbench
  import eii_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        nmi_pin;
  logic        hw_standby;
  logic        flash_busy;
  logic        wdt_overflow;
  logic        wdt_interval_mode;
  logic        take;
  logic        hreadyout;
  logic        hresp;
  logic        rd_dph = 1'b0;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [2:0]  cpu_mask_level;
  logic [3:0]  irq_pin_n;
  logic [3:0]  pin_function;
  logic [3:0]  lag;
  eii_ack_t    cpu_ack;
  eii_req_t    cpu_req;
  eii_mask_t   cpu_mask;
  logic [31:0] rq[$];
  logic [4:0]  mq[$];
  int          fail_count;
  int          n_checks;

  eii_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n),
    .hw_standby(hw_standby), .flash_busy(flash_busy), .wdt_overflow(wdt_overflow),
    .wdt_interval_mode(wdt_interval_mode), .cpu_mask_level(cpu_mask_level), .cpu_ack(cpu_ack),
    .cpu_req(cpu_req), .cpu_mask(cpu_mask), .pin_function(pin_function));

  eii_cpu_model u_cpu (.hclk(hclk), .hresetn(hresetn), .take(take), .lag(lag), .cpu_req(cpu_req),
    .cpu_mask(cpu_mask), .cpu_ack(cpu_ack), .cpu_mask_level(cpu_mask_level));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // address phase held until hready, then data phase held until hready
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    rq.push_back({24'h0, exp});
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic pulse_pin(input int i);
    irq_pin_n[i] <= 1'b0;
    repeat (4) @(posedge hclk);
    irq_pin_n[i] <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask

  task automatic wdt_pulse;
    @(posedge hclk);
    wdt_overflow <= 1'b1;
    @(posedge hclk);
    wdt_overflow <= 1'b0;
  endtask

  // request must stand at the cpu, then one accept must bring exactly one mask update
  task automatic req_accept(input eii_src_t s, input logic [3:0] lvl, input logic d, input logic [2:0] m);
    repeat (6) @(posedge hclk);
    check("cpu_req", {23'h0, 1'b1, s, lvl, d}, {23'h0, cpu_req});
    mq.push_back({2'b11, m});
    seed = lfsr(seed);
    lag  <= {2'b00, seed[1:0]};
    take <= 1'b1;
    for (int i = 0; i < 60 && mq.size() != 0; i++) @(posedge hclk);
    check("accept_seen", 32'h0, mq.size());
    take <= 1'b0;
    repeat (14) @(posedge hclk);
  endtask

  // ------------------------------------------------------------
  // result monitor
  // ------------------------------------------------------------
  always @(posedge hclk) begin
    if (rd_dph && hreadyout) begin
      check("hrdata", rq.size() ? rq.pop_front() : 32'hFFFFFFFF, hrdata);
      check("hresp", 32'h0, {31'h0, hresp});
    end
    rd_dph = hresetn && hsel && htrans[1] && !hwrite && hreadyout;
    if (cpu_mask.update === 1'b1) begin
      check("cpu_mask", mq.size() ? {27'h0, mq.pop_front()} : 32'h0, {27'h0, cpu_mask});
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    nmi_pin = 1'b1;
    irq_pin_n = 4'hF;
    hw_standby = 1'b0;
    flash_busy = 1'b0;
    wdt_overflow = 1'b0;
    wdt_interval_mode = 1'b0;
    take = 1'b0;
    lag = 4'h0;
    seed = 32'hC1771032;
    fail_count = 0;
    n_checks = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(EII_ADDR_FLAGS, 8'hF1);
    rd(EII_ADDR_NMI_CTRL, 8'hFE);
    rd(EII_ADDR_ENABLE, 8'hF0);
    rd(32'h00000100, 8'h00);
    check("pin_function", 32'h0, {28'h0, pin_function});
    pulse_pin(1);
    rd(EII_ADDR_FLAGS, 8'hF1);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(EII_ADDR_NMI_CTRL, 1'b1, seed);
      rd(EII_ADDR_NMI_CTRL, {7'h7F, seed[0]});
      bus(EII_ADDR_ENABLE, 1'b1, seed);
      rd(EII_ADDR_ENABLE, {4'hF, seed[3:0]});
    end
    bus(EII_ADDR_NMI_CTRL, 1'b1, 32'h0);
    bus(EII_ADDR_ENABLE, 1'b1, 32'h0E);
    bus(EII_ADDR_PRIO_A, 1'b1, 32'h53);
    bus(EII_ADDR_XFER_A, 1'b1, 32'h10);
    check("pin_function", 32'hE, {28'h0, pin_function});
    $display("read only bits done");
    for (int i = 1; i < 4; i++) pulse_pin(i);
    bus(EII_ADDR_FLAGS, 1'b1, 32'h0);
    rd(EII_ADDR_FLAGS, 8'hFF);
    bus(EII_ADDR_FLAGS, 1'b1, 32'hFF);
    rd(EII_ADDR_FLAGS, 8'hFF);
    bus(EII_ADDR_FLAGS, 1'b1, 32'h0);
    rd(EII_ADDR_FLAGS, 8'hF1);
    $display("flag clearing done");
    for (int i = 1; i < 4; i++) begin
      pulse_pin(i);
      req_accept(eii_src_t'(i + 2), 4'h3, 1'b0, 3'h3);
      rd(EII_ADDR_FLAGS, 8'hF1);
    end
    $display("edge lines done");
    bus(EII_ADDR_ENABLE, 1'b1, 32'h0F);
    irq_pin_n[0] <= 1'b0;
    req_accept(EII_SRC_LINE0, 4'h5, 1'b1, 3'h5);
    irq_pin_n[0] <= 1'b1;
    wdt_interval_mode <= 1'b1;
    wdt_pulse();
    req_accept(EII_SRC_WATCHDOG, 4'h5, 1'b1, 3'h5);
    wdt_interval_mode <= 1'b0;
    wdt_pulse();
    repeat (10) @(posedge hclk);
    check("cpu_req_valid", 32'h0, {31'h0, cpu_req.valid});
    $display("line zero done");
    nmi_pin <= 1'b0;
    req_accept(EII_SRC_NMI, EII_NMI_LEVEL, 1'b0, EII_NMI_MASK);
    nmi_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    flash_busy <= 1'b1;
    nmi_pin    <= 1'b0;
    repeat (8) @(posedge hclk);
    check("cpu_req_valid", 32'h0, {31'h0, cpu_req.valid});
    flash_busy <= 1'b0;
    bus(EII_ADDR_NMI_CTRL, 1'b1, 32'h01);
    repeat (8) @(posedge hclk);
    nmi_pin <= 1'b1;
    req_accept(EII_SRC_NMI, EII_NMI_LEVEL, 1'b0, EII_NMI_MASK);
    $display("nonmask input done");
    bus(EII_ADDR_ENABLE, 1'b1, 32'hFF);
    hw_standby <= 1'b1;
    repeat (5) @(posedge hclk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge hclk);
    rd(EII_ADDR_ENABLE, 8'hF0);
    rd(EII_ADDR_NMI_CTRL, 8'hFE);
    check("pin_function", 32'h0, {28'h0, pin_function});
    $display("hardware standby done");
    repeat (4) @(posedge hclk);
    stop_test();
  end
endmodule

// ===== verilog/eii_pkg.sv
// package: register map, reset values, field positions and carrier types of the external interrupt inputs
package eii_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] EII_IDX_FLAGS    = 16'hFEDE;
  localparam logic [15:0] EII_IDX_NMI_CTRL = 16'hFF1C;
  localparam logic [15:0] EII_IDX_ENABLE   = 16'hFF1D;
  localparam logic [15:0] EII_IDX_PRIO_A   = 16'hFF00;
  localparam logic [15:0] EII_IDX_XFER_A   = 16'hFF08;
  localparam logic [15:0] EII_IDX_STATUS   = 16'hFF1E;

  localparam logic [31:0] EII_ADDR_FLAGS    = {14'h0000, EII_IDX_FLAGS, 2'h0};
  localparam logic [31:0] EII_ADDR_NMI_CTRL = {14'h0000, EII_IDX_NMI_CTRL, 2'h0};
  localparam logic [31:0] EII_ADDR_ENABLE   = {14'h0000, EII_IDX_ENABLE, 2'h0};
  localparam logic [31:0] EII_ADDR_PRIO_A   = {14'h0000, EII_IDX_PRIO_A, 2'h0};
  localparam logic [31:0] EII_ADDR_XFER_A   = {14'h0000, EII_IDX_XFER_A, 2'h0};
  localparam logic [31:0] EII_ADDR_STATUS   = {14'h0000, EII_IDX_STATUS, 2'h0};

  // ----------------------------------------------------------------
  // reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0] EII_RST_NMI_CTRL = 8'hFE;
  localparam logic [7:0] EII_RST_ENABLE   = 8'hF0;
  localparam logic [7:0] EII_RST_FLAGS    = 8'hF1;
  localparam logic [7:0] EII_RST_PRIO_A   = 8'h00;
  localparam logic [7:0] EII_RST_XFER_A   = 8'h00;
  localparam logic [6:0] EII_ONES_NMI_HI  = 7'h7F;
  localparam logic [3:0] EII_ONES_NIBBLE  = 4'hF;
  localparam logic [3:0] EII_NMI_LEVEL    = 4'h8;
  localparam logic [2:0] EII_NMI_MASK     = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EII_BIT_EDGE_SEL  = 0;
  localparam int EII_PRIO_HI_LSB   = 4;
  localparam int EII_PRIO_LO_LSB   = 0;
  localparam int EII_XFER_LINE0    = 4;
  localparam int EII_XFER_LINE1    = 2;
  localparam int EII_XFER_LINE2    = 1;
  localparam int EII_XFER_LINE3    = 0;
  localparam int EII_NSRC          = 6;
  localparam int EII_NSYNC         = 6;
  // sync idle: nmi high, four request pins high, standby low
  localparam logic [5:0] EII_SYNC_IDLE = 6'h1F;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EII_SRC_NMI,
    EII_SRC_LINE0,
    EII_SRC_WATCHDOG,
    EII_SRC_LINE1,
    EII_SRC_LINE2,
    EII_SRC_LINE3
  } eii_src_t;

  typedef struct packed {
    logic       valid;
    eii_src_t   source;
    logic [3:0] level;
    logic       xfer_ctrl;
  } eii_req_t;

  typedef struct packed {
    logic     accept;
    eii_src_t source;
  } eii_ack_t;

  typedef struct packed {
    logic       update;
    logic       clear_trace;
    logic [2:0] level;
  } eii_mask_t;

endpackage

// ===== verilog/eii_top.sv
// external interrupt inputs: nmi edge, line 0 level and watchdog, lines 1-3 edge with pending flags
//
// Summary of operation
// - nmi is level 8, never masked
// - nmi edge: falling if select 0, rising if 1
// - nmi accept: clear trace, mask level 7
// - nmi ignored while flash programs or erases
// - edge control resets to FE, kept otherwise; hardware standby resets it too
// - edge control bits 7-1 read one
// - line 0 pin and watchdog, separate vectors
// - line 0 pin low requests when enabled
// - watchdog overflow requests in interval mode
// - line 0 priority upper nibble, transfer bit 4
// - line 0 accept: clear trace, upper priority
// - lines 1-3 falling edge when enabled
// - lines 1-3 lower nibble, transfer bits 2-0
// - lines 1-3 accept: clear trace, lower priority
// - request enable resets to F0
// - enable bits select pin function
// - enable and flag bits 7-4 read one
// - enabled edge sets matching pending flag
// - clear flag by read one then write zero
// - accept clears that line's pending flag
// - request flags reset to F1
// - flag bit 0 reserved, reads one
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module eii_top
  import eii_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        nmi_pin,
  input  wire logic [3:0]  irq_pin_n,
  input  wire logic        hw_standby,
  input  wire logic        flash_busy,
  input  wire logic        wdt_overflow,
  input  wire logic        wdt_interval_mode,
  input  wire logic [2:0]  cpu_mask_level,
  input  wire eii_ack_t    cpu_ack,
  output eii_req_t         cpu_req,
  output eii_mask_t        cpu_mask,
  output logic      [3:0]  pin_function
);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync_meta;
  logic [5:0] sync_pin;
  logic [5:0] sync_prev;
  wire  [5:0] sync_raw = {hw_standby, irq_pin_n, nmi_pin};

  genvar gi;
  generate
    for (gi = 0; gi < EII_NSYNC; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync_meta[gi] <= EII_SYNC_IDLE[gi];
          sync_pin[gi]  <= EII_SYNC_IDLE[gi];
          sync_prev[gi] <= EII_SYNC_IDLE[gi];
        end else begin
          sync_meta[gi] <= sync_raw[gi];
          sync_pin[gi]  <= sync_meta[gi];
          sync_prev[gi] <= sync_pin[gi];
        end
      end
    end
  endgenerate

  wire       nmi_now    = sync_pin[0];
  wire       nmi_was    = sync_prev[0];
  wire [3:0] line_now_n = sync_pin[4:1];
  wire [3:0] line_was_n = sync_prev[4:1];
  // hardware standby acts like reset on the registers while it is held
  wire       standby    = sync_pin[5];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic       edge_sel;
  logic [3:0] ext_enable;
  logic [3:1] line_pending;
  logic [3:1] flag_armed;
  logic [7:0] prio_a;
  logic [7:0] xfer_a;
  logic       nmi_pending;
  logic       wdt_pending;

  // ----------------------------------------------------------------
  // bus slave: address phase capture
  // ----------------------------------------------------------------
  wire ap_take  = hsel & htrans[1] & hready;
  wire sel_flag = haddr == EII_ADDR_FLAGS;
  wire sel_nmi  = haddr == EII_ADDR_NMI_CTRL;
  wire sel_en   = haddr == EII_ADDR_ENABLE;
  wire sel_prio = haddr == EII_ADDR_PRIO_A;
  wire sel_xfer = haddr == EII_ADDR_XFER_A;
  wire sel_stat = haddr == EII_ADDR_STATUS;
  wire ap_read  = ap_take & ~hwrite;

  logic dp_flag;
  logic dp_nmi;
  logic dp_en;
  logic dp_prio;
  logic dp_xfer;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_flag <= 1'b0;
      dp_nmi  <= 1'b0;
      dp_en   <= 1'b0;
      dp_prio <= 1'b0;
      dp_xfer <= 1'b0;
    end else begin
      dp_flag <= ap_take & hwrite & sel_flag;
      dp_nmi  <= ap_take & hwrite & sel_nmi;
      dp_en   <= ap_take & hwrite & sel_en;
      dp_prio <= ap_take & hwrite & sel_prio;
      dp_xfer <= ap_take & hwrite & sel_xfer;
    end
  end

  wire [7:0] rd_flags = {EII_ONES_NIBBLE, line_pending, 1'b1};
  wire [7:0] rd_nmi   = {EII_ONES_NMI_HI, edge_sel};
  wire [7:0] rd_en    = {EII_ONES_NIBBLE, ext_enable};
  wire [7:0] rd_stat  = {5'h00, flash_busy, wdt_pending, nmi_pending};
  // unmapped addresses read zero and take writes silently, always OKAY
  wire [7:0] rd_byte  = sel_flag ? rd_flags :
                        sel_nmi  ? rd_nmi   :
                        sel_en   ? rd_en    :
                        sel_prio ? prio_a   :
                        sel_xfer ? xfer_a   :
                        sel_stat ? rd_stat  : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= ap_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_sel   <= EII_RST_NMI_CTRL[EII_BIT_EDGE_SEL];
      ext_enable <= EII_RST_ENABLE[3:0];
      prio_a     <= EII_RST_PRIO_A;
      xfer_a     <= EII_RST_XFER_A;
    end else if (standby) begin
      edge_sel   <= EII_RST_NMI_CTRL[EII_BIT_EDGE_SEL];
      ext_enable <= EII_RST_ENABLE[3:0];
      prio_a     <= EII_RST_PRIO_A;
      xfer_a     <= EII_RST_XFER_A;
    end else begin
      if (dp_nmi) begin
        edge_sel <= hwdata[EII_BIT_EDGE_SEL];
      end
      if (dp_en) begin
        ext_enable <= hwdata[3:0];
      end
      if (dp_prio) begin
        prio_a <= hwdata[7:0];
      end
      if (dp_xfer) begin
        xfer_a <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_function <= EII_RST_ENABLE[3:0];
    end else begin
      pin_function <= standby ? EII_RST_ENABLE[3:0] : (dp_en ? hwdata[3:0] : ext_enable);
    end
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  wire       nmi_edge  = edge_sel ? (nmi_now & ~nmi_was) : (~nmi_now & nmi_was);
  wire       nmi_set   = nmi_edge & ~flash_busy;
  wire       wdt_set   = wdt_overflow & wdt_interval_mode;
  wire       line0_req = ~line_now_n[0] & ext_enable[0];
  wire [3:1] line_fall = ~line_now_n[3:1] & line_was_n[3:1];
  wire [3:1] line_set  = line_fall & ext_enable[3:1];

  wire ack_nmi = cpu_ack.accept & (cpu_ack.source == EII_SRC_NMI);
  wire ack_wdt = cpu_ack.accept & (cpu_ack.source == EII_SRC_WATCHDOG);
  wire [3:1] ack_line = {cpu_ack.accept & (cpu_ack.source == EII_SRC_LINE3),
                         cpu_ack.accept & (cpu_ack.source == EII_SRC_LINE2),
                         cpu_ack.accept & (cpu_ack.source == EII_SRC_LINE1)};

  // a flag read as one arms its clear; the next write to the flags, if it writes zero to that bit, cancels the request
  wire [3:1] arm_set  = {3{ap_read & sel_flag}} & line_pending;
  wire [3:1] sw_clear = {3{dp_flag}} & flag_armed & ~hwdata[3:1];
  wire [3:1] clr_vec  = sw_clear | ack_line;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_pending <= EII_RST_FLAGS[3:1];
      flag_armed   <= 3'h0;
      nmi_pending  <= 1'b0;
      wdt_pending  <= 1'b0;
    end else if (standby) begin
      line_pending <= EII_RST_FLAGS[3:1];
      flag_armed   <= 3'h0;
      nmi_pending  <= 1'b0;
      wdt_pending  <= 1'b0;
    end else begin
      // set wins over either clear so an edge in the clearing cycle survives
      line_pending <= line_set | (line_pending & ~clr_vec);
      flag_armed   <= arm_set | (flag_armed & ~({3{dp_flag}} | ack_line));
      nmi_pending  <= nmi_set | (nmi_pending & ~ack_nmi);
      wdt_pending  <= wdt_set | (wdt_pending & ~ack_wdt);
    end
  end

  // ----------------------------------------------------------------
  // arbitration towards the cpu
  // ----------------------------------------------------------------
  wire [3:0] lvl_hi = {1'b0, prio_a[EII_PRIO_HI_LSB +: 3]};
  wire [3:0] lvl_lo = {1'b0, prio_a[EII_PRIO_LO_LSB +: 3]};
  wire [5:0] cand_vld = {line_pending[3], line_pending[2], line_pending[1], wdt_pending, line0_req, nmi_pending};
  wire [23:0] cand_lvl = {lvl_lo, lvl_lo, lvl_lo, lvl_hi, lvl_hi, EII_NMI_LEVEL};
  wire [5:0] cand_xfer = {xfer_a[EII_XFER_LINE3], xfer_a[EII_XFER_LINE2], xfer_a[EII_XFER_LINE1],
                          xfer_a[EII_XFER_LINE0], xfer_a[EII_XFER_LINE0], 1'b0};

  // highest level wins; equal levels keep the fixed order nmi, line 0, watchdog, lines 1-3
  function automatic logic [2:0] pick(input logic [5:0] vld, input logic [23:0] lvl);
    logic [2:0] best;
    logic [3:0] best_lvl;
    best     = 3'h0;
    best_lvl = 4'h0;
    for (int i = EII_NSRC - 1; i >= 0; i--) begin
      if (vld[i] && lvl[i*4 +: 4] >= best_lvl) begin
        best     = 3'(i);
        best_lvl = lvl[i*4 +: 4];
      end
    end
    return best;
  endfunction

  wire [2:0] win_idx = pick(cand_vld, cand_lvl);
  wire [3:0] win_lvl = cand_lvl[win_idx*4 +: 4];
  // the mask never blocks nmi; level 0 never beats any mask
  wire       win_ok  = cand_vld[win_idx] & ((win_idx == 3'h0) | (win_lvl > {1'b0, cpu_mask_level}));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_req <= '0;
    end else begin
      cpu_req.valid     <= win_ok;
      cpu_req.source    <= eii_src_t'(win_idx);
      cpu_req.level     <= win_lvl;
      cpu_req.xfer_ctrl <= cand_xfer[win_idx];
    end
  end

  // ----------------------------------------------------------------
  // acceptance: mask update and trace clear
  // ----------------------------------------------------------------
  wire       ack_hi   = cpu_ack.accept & ((cpu_ack.source == EII_SRC_LINE0) | (cpu_ack.source == EII_SRC_WATCHDOG));
  wire [2:0] next_lvl = ack_nmi ? EII_NMI_MASK : (ack_hi ? lvl_hi[2:0] : lvl_lo[2:0]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_mask <= '0;
    end else begin
      cpu_mask.update      <= cpu_ack.accept;
      cpu_mask.clear_trace <= cpu_ack.accept;
      cpu_mask.level       <= next_lvl;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence nmi_fall_s;
    !edge_sel && nmi_was && !nmi_now;
  endsequence
  sequence nmi_rise_s;
    edge_sel && !nmi_was && nmi_now;
  endsequence

  nmi_top_prio_a: assert property (nmi_pending |=> cpu_req.valid && cpu_req.source == EII_SRC_NMI
    && cpu_req.level == 4'h8) else $error("nmi not presented at level 8");
  nmi_fall_edge_a: assert property ((nmi_fall_s or nmi_rise_s) ##0 !flash_busy && !standby |=> nmi_pending)
    else $error("selected nmi edge not latched");
  nmi_wrong_edge_a: assert property (edge_sel && nmi_was && !nmi_now && !nmi_pending |=> !nmi_pending)
    else $error("nmi latched on unselected edge");
  nmi_accept_mask_a: assert property (ack_nmi |=> cpu_mask.update && cpu_mask.clear_trace
    && cpu_mask.level == 3'h7) else $error("nmi accept did not give mask 7");
  flash_block_a: assert property (flash_busy && !nmi_pending && !standby |=> !nmi_pending)
    else $error("nmi taken during flash programming");
  nmi_ctrl_read_a: assert property (ap_read && sel_nmi |=> hrdata[7:1] == 7'h7F)
    else $error("edge control upper bits not ones");
  line0_level_a: assert property (line0_req && !nmi_pending && lvl_hi >= lvl_lo
    && lvl_hi > {1'b0, cpu_mask_level} |=> cpu_req.valid && cpu_req.source == EII_SRC_LINE0)
    else $error("line 0 level request lost");
  wdt_request_a: assert property (wdt_set && !standby |=> wdt_pending)
    else $error("watchdog overflow not latched");
  line0_accept_a: assert property (cpu_ack.accept && cpu_ack.source == EII_SRC_LINE0
    |=> cpu_mask.level == $past(prio_a[6:4])) else $error("line 0 accept mask wrong");
  line_accept_a: assert property (ack_line != 3'h0 |=> cpu_mask.level == $past(prio_a[2:0]))
    else $error("line 1-3 accept mask wrong");
  flag_set_a: assert property (line_set != 3'h0 && !standby
    |=> (line_pending & $past(line_set)) == $past(line_set))
    else $error("enabled edge did not set flag");
  flag_clear_a: assert property (##1 !$past(standby) |->
    (($past(line_pending) & ~line_pending & ~$past(clr_vec)) == 3'h0)) else $error("flag cleared without cause");
  flag_read_a: assert property (ap_read && sel_flag |=> hrdata[7:4] == 4'hF && hrdata[0])
    else $error("flag register fixed bits wrong");

  // ----------------------------------------------------------------
  // assertions: standby, transfer routing, flag clearing
  // ----------------------------------------------------------------
  wire [3:1] ack_only  = ack_line & ~line_set;
  wire [3:1] keep_one  = line_pending & hwdata[3:1] & ~ack_line;
  wire [3:1] keep_idle = line_pending & ~flag_armed & ~ack_line;

  sequence standby_s;
    standby;
  endsequence
  sequence line_ack_s;
    ack_only != 3'h0 && !standby;
  endsequence
  sequence flag_write_s;
    dp_flag && !standby;
  endsequence

  // standby takes effect at the next edge and holds the reset values while it stays high
  standby_reset_a: assert property (standby_s |=> !edge_sel && ext_enable == 4'h0
    && line_pending == 3'h0 && !nmi_pending && !wdt_pending) else $error("standby did not restore reset values");

  pin_func_a: assert property (pin_function == ext_enable)
    else $error("pin function differs from enable bits");

  // lines 2 and 3 have transfer bits of their own, but only the routes of line 0 and line 1 are watched
  line0_route_a: assert property (cpu_req.valid && cpu_req.source == EII_SRC_LINE0
    |-> cpu_req.xfer_ctrl == $past(xfer_a[EII_XFER_LINE0])) else $error("line 0 transfer route wrong");
  line1_route_a: assert property (cpu_req.valid && cpu_req.source == EII_SRC_LINE1
    |-> cpu_req.xfer_ctrl == $past(xfer_a[EII_XFER_LINE1])) else $error("line 1 transfer route wrong");

  line_ack_clear_a: assert property (line_ack_s |=> (line_pending & $past(ack_only)) == 3'h0)
    else $error("accepted line flag not cleared");

  // a flag survives a write of one, and a write of zero that no read of one has armed
  flag_write_one_a: assert property (flag_write_s |=>
    ($past(keep_one) & ~line_pending) == 3'h0) else $error("writing one cleared a flag");
  flag_unarmed_a: assert property (flag_write_s |=>
    ($past(keep_idle) & ~line_pending) == 3'h0) else $error("unarmed flag cleared");

endmodule
